// File: rtl/dswsl_top.v
// Purpose: single-wire half-duplex serial front end of the debug unit
// Assumes: core_clk 25 MHz, APB slave, open-drain debug pin with pull-up
// Notes: command decode, halt, memory access and check values live elsewhere
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "dswsl_map.vh"
module dswsl_top (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire pin_share_option,
  input wire clock_changed,
  input wire debug_pin_in,
  output reg debug_pin_out,
  output reg debug_pin_oe,
  output wire debug_pin_owned,
  output reg cmd_abort_q
);
  localparam T_IDLE = 3'd0;
  localparam T_WAITFC = 3'd1;
  localparam T_START = 3'd2;
  localparam T_DATA = 3'd3;
  localparam T_STOP = 3'd4;
  localparam T_BREAK = 3'd5;
  localparam R_IDLE = 2'd0;
  localparam R_START = 2'd1;
  localparam R_DATA = 2'd2;
  localparam R_STOP = 2'd3;

  reg [8:0] ctrl_q;
  reg [15:0] reload_q;
  reg [2:0] tx_state_q;
  reg [12:0] tx_cnt_q;
  reg [3:0] tx_bit_q;
  reg [8:0] tx_shift_q;
  reg tx_hi_q;
  reg [1:0] rx_state_q;
  reg [12:0] rx_cnt_q;
  reg [3:0] rx_bit_q;
  reg [8:0] rx_shift_q;
  reg [8:0] rx_data_q;
  reg rx_valid_q;
  reg frame_err_q;
  reg coll_q;
  reg init_done_q;
  reg omit_check_q;
  reg line_q;
  wire line_sync;
  wire fall;
  wire rise;
  wire abd_done;
  wire [15:0] abd_count;

  // Register decode shared by read and write paths
  function [2:0] reg_index;
    input [11:0] addr;
    begin
      case (addr)
        `DSWSL_OFF_CTRL: reg_index = 3'd1;
        `DSWSL_OFF_RELOAD: reg_index = 3'd2;
        `DSWSL_OFF_TXDATA: reg_index = 3'd3;
        `DSWSL_OFF_STATUS: reg_index = 3'd4;
        `DSWSL_OFF_RXDATA: reg_index = 3'd5;
        default: reg_index = 3'd0;
      endcase
    end
  endfunction

  // Clamp a reload value to 12 bits while the debug unit owns the pin
  function [15:0] clamp_reload;
    input [15:0] val;
    input en;
    begin
      if (en && val > `DSWSL_RELOAD_EN_MAX)
        clamp_reload = `DSWSL_RELOAD_EN_MAX;
      else
        clamp_reload = val;
    end
  endfunction

  wire enabled = ctrl_q[`DSWSL_CTL_EN];
  wire nine = ctrl_q[`DSWSL_CTL_NINE];
  wire [3:0] last_bit = nine ? 4'd8 : 4'd7;
  // Bit time is reload / 8, never below one clock
  wire [12:0] bit_len = (reload_q[15:3] == 13'h0000) ? 13'h0001 : reload_q[15:3];
  wire [12:0] half_len = {1'b0, bit_len[12:1]};
  wire apb_access = psel && penable;
  wire [2:0] widx = reg_index(paddr);
  wire apb_wr = apb_access && pwrite;
  wire apb_rd = apb_access && !pwrite;
  wire tx_load = apb_wr && widx == 3'd3 && tx_state_q == T_IDLE;
  wire tx_active = tx_state_q != T_IDLE && tx_state_q != T_BREAK;
  wire tx_end = tx_cnt_q == bit_len - 13'h0001;
  wire tx_mid = tx_cnt_q == half_len;
  wire rx_tick = rx_cnt_q == 13'h0000;
  wire abs_flag = ctrl_q[`DSWSL_CTL_ABS];
  // Collision: sending a one but the pin reads low at mid-bit
  wire coll_evt = tx_mid && tx_hi_q && !line_sync &&
                  (tx_state_q == T_DATA || tx_state_q == T_STOP);
  wire ferr_evt = rx_state_q == R_STOP && rx_tick && !line_sync;
  wire err_break = enabled && (coll_evt || ferr_evt);
  wire go_break = err_break || (enabled && clock_changed);

  assign pready = 1'b1;
  assign pslverr = apb_access && widx == 3'd0;
  assign debug_pin_owned = enabled;

  dswsl_sync u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin_in(debug_pin_in),
    .pin_sync(line_sync)
  );

  // Edge detect reads only the second synchronizer stage
  always @(posedge core_clk) begin
    if (reset)
      line_q <= 1'b1;
    else if (clk_en)
      line_q <= line_sync;
  end
  assign fall = line_q && !line_sync;
  assign rise = !line_q && line_sync;

  dswsl_abd u_abd (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .arm(abs_flag && !tx_active && tx_state_q != T_BREAK),
    .sel_cr(ctrl_q[`DSWSL_CTL_CR] && !enabled),
    .fall(fall),
    .rise(rise),
    .done_q(abd_done),
    .count_q(abd_count)
  );

  // Control and reload registers; hardware events win over software writes
  always @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= 9'h000;
      ctrl_q[`DSWSL_CTL_EN] <= 1'b1;
      ctrl_q[`DSWSL_CTL_LOCK] <= pin_share_option;
      ctrl_q[`DSWSL_CTL_SHARE] <= pin_share_option;
      ctrl_q[`DSWSL_CTL_ABS] <= 1'b1;
      reload_q <= `DSWSL_RELOAD_RST;
    end else if (clk_en) begin
      if (apb_wr && widx == 3'd1) begin
        ctrl_q[8:4] <= pwdata[8:4];
        ctrl_q[`DSWSL_CTL_ABS] <= pwdata[`DSWSL_CTL_ABS];
        // Lock is set-only by software; share option is read-only
        if (pwdata[`DSWSL_CTL_LOCK])
          ctrl_q[`DSWSL_CTL_LOCK] <= 1'b1;
        if (pwdata[`DSWSL_CTL_EN])
          ctrl_q[`DSWSL_CTL_EN] <= 1'b1;
        else if (!ctrl_q[`DSWSL_CTL_LOCK] && !ctrl_q[`DSWSL_CTL_SHARE])
          ctrl_q[`DSWSL_CTL_EN] <= 1'b0;
        // Switching to carriage return calibration only while disabled or in the write that disables
        if (enabled && !(pwdata[`DSWSL_CTL_EN] == 1'b0 &&
            !ctrl_q[`DSWSL_CTL_LOCK] && !ctrl_q[`DSWSL_CTL_SHARE]))
          ctrl_q[`DSWSL_CTL_CR] <= 1'b0;
      end
      if (apb_wr && widx == 3'd2)
        reload_q <= clamp_reload(pwdata[15:0], enabled);
      if (abd_done) begin
        reload_q <= clamp_reload(abd_count, enabled);
        ctrl_q[`DSWSL_CTL_ABS] <= 1'b0;
      end
      if (go_break || (!enabled && clock_changed))
        ctrl_q[`DSWSL_CTL_ABS] <= 1'b1;
      if (enabled && reload_q > `DSWSL_RELOAD_EN_MAX)
        reload_q <= `DSWSL_RELOAD_EN_MAX;
    end
  end

  // Transmitter: start, data LSB first, optional ninth bit, stop, break
  always @(posedge core_clk) begin
    if (reset) begin
      tx_state_q <= T_IDLE;
      tx_cnt_q <= 13'h0000;
      tx_bit_q <= 4'h0;
      tx_shift_q <= 9'h000;
      tx_hi_q <= 1'b1;
      cmd_abort_q <= 1'b0;
    end else if (clk_en) begin
      cmd_abort_q <= 1'b0;
      tx_cnt_q <= tx_cnt_q + 13'h0001;
      if (go_break) begin
        tx_state_q <= T_BREAK;
        tx_cnt_q <= 13'h0000;
        tx_hi_q <= 1'b0;
        cmd_abort_q <= 1'b1;
      end else begin
        case (tx_state_q)
          T_IDLE: begin
            tx_hi_q <= 1'b1;
            if (tx_load && rx_state_q == R_IDLE && !abs_flag) begin
              tx_shift_q <= pwdata[8:0];
              tx_cnt_q <= 13'h0000;
              tx_hi_q <= ctrl_q[`DSWSL_CTL_FC];
              tx_state_q <= ctrl_q[`DSWSL_CTL_FC] ? T_WAITFC : T_START;
            end
          end
          T_WAITFC: begin
            tx_cnt_q <= 13'h0000;
            if (fall)
              tx_state_q <= T_START;
          end
          T_START: begin
            if (tx_end) begin
              tx_cnt_q <= 13'h0000;
              tx_bit_q <= 4'h0;
              tx_hi_q <= tx_shift_q[0];
              tx_state_q <= T_DATA;
            end
          end
          T_DATA: begin
            if (tx_end) begin
              tx_cnt_q <= 13'h0000;
              tx_shift_q <= {1'b0, tx_shift_q[8:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == last_bit) begin
                tx_hi_q <= 1'b1;
                tx_state_q <= T_STOP;
              end else begin
                tx_hi_q <= tx_shift_q[1];
              end
            end
          end
          T_STOP: begin
            if (tx_end)
              tx_state_q <= T_IDLE;
          end
          T_BREAK: begin
            if (tx_cnt_q == `DSWSL_BREAK_CLKS - 13'h0001) begin
              tx_hi_q <= 1'b1;
              tx_state_q <= T_IDLE;
            end
          end
          default: tx_state_q <= T_IDLE;
        endcase
      end
    end
  end

  // Pin driver: low always driven, high only as the line control bits allow
  always @* begin
    debug_pin_out = 1'b0;
    debug_pin_oe = 1'b0;
    if (tx_state_q == T_BREAK || (tx_active && tx_state_q != T_WAITFC && !tx_hi_q)) begin
      debug_pin_oe = 1'b1;
    end else if (tx_active && tx_state_q != T_WAITFC) begin
      debug_pin_out = 1'b1;
      if (ctrl_q[`DSWSL_CTL_OE] && ctrl_q[`DSWSL_CTL_DH])
        debug_pin_oe = tx_cnt_q == 13'h0000;
      else if (ctrl_q[`DSWSL_CTL_OE])
        debug_pin_oe = 1'b1;
      else if (ctrl_q[`DSWSL_CTL_DH])
        debug_pin_oe = !line_sync && tx_cnt_q < half_len;
    end
  end

  // Receiver: mid-bit sampling, held off while transmitting
  always @(posedge core_clk) begin
    if (reset) begin
      rx_state_q <= R_IDLE;
      rx_cnt_q <= 13'h0000;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 9'h000;
    end else if (clk_en) begin
      rx_cnt_q <= rx_cnt_q - 13'h0001;
      case (rx_state_q)
        R_IDLE: begin
          if (fall && tx_state_q == T_IDLE && !abs_flag) begin
            rx_cnt_q <= half_len;
            rx_state_q <= R_START;
          end
        end
        R_START: begin
          if (rx_tick) begin
            rx_cnt_q <= bit_len - 13'h0001;
            rx_bit_q <= 4'h0;
            rx_state_q <= line_sync ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (rx_tick) begin
            rx_cnt_q <= bit_len - 13'h0001;
            rx_shift_q <= nine ? {line_sync, rx_shift_q[8:1]}
                               : {1'b0, line_sync, rx_shift_q[7:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == last_bit)
              rx_state_q <= R_STOP;
          end
        end
        R_STOP: begin
          if (rx_tick)
            rx_state_q <= R_IDLE;
        end
        default: rx_state_q <= R_IDLE;
      endcase
    end
  end

  // Received character, error flags and the initialization gate
  always @(posedge core_clk) begin
    if (reset) begin
      rx_data_q <= 9'h000;
      rx_valid_q <= 1'b0;
      frame_err_q <= 1'b0;
      coll_q <= 1'b0;
      init_done_q <= 1'b0;
      omit_check_q <= 1'b0;
    end else if (clk_en) begin
      if (apb_rd && widx == 3'd5)
        rx_valid_q <= 1'b0;
      if (apb_wr && widx == 3'd4) begin
        if (pwdata[`DSWSL_ST_FRAMERR])
          frame_err_q <= 1'b0;
        if (pwdata[`DSWSL_ST_COLL])
          coll_q <= 1'b0;
        if (pwdata[`DSWSL_ST_OMIT])
          omit_check_q <= 1'b0;
      end
      if (ferr_evt)
        frame_err_q <= 1'b1;
      if (coll_evt)
        coll_q <= 1'b1;
      if (rx_state_q == R_STOP && rx_tick && line_sync) begin
        if (init_done_q || rx_shift_q[7:0] == `DSWSL_CMD_READ_REV) begin
          rx_data_q <= rx_shift_q;
          rx_valid_q <= 1'b1;
          if (!init_done_q)
            omit_check_q <= 1'b1;
          init_done_q <= 1'b1;
        end
      end
    end
  end

  // APB read data is captured in the setup cycle for a zero-wait access
  always @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable) begin
      case (widx)
        3'd1: prdata <= {23'h000000, ctrl_q};
        3'd2: prdata <= {16'h0000, reload_q};
        3'd4: prdata <= {25'h0000000, tx_state_q == T_BREAK, omit_check_q, init_done_q,
                         coll_q, frame_err_q, rx_valid_q, tx_state_q != T_IDLE};
        3'd5: prdata <= {23'h000000, rx_data_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// File: rtl/dswsl_map.vh
// Purpose: constants for the single-wire debug serial link
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: included only by the top design file
`ifndef DSWSL_MAP_VH
`define DSWSL_MAP_VH

// Register byte offsets
`define DSWSL_OFF_CTRL 12'h000
`define DSWSL_OFF_RELOAD 12'h004
`define DSWSL_OFF_TXDATA 12'h008
`define DSWSL_OFF_STATUS 12'h00C
`define DSWSL_OFF_RXDATA 12'h010

// Control register fields
`define DSWSL_CTL_EN 0
`define DSWSL_CTL_LOCK 1
`define DSWSL_CTL_SHARE 2
`define DSWSL_CTL_ABS 3
`define DSWSL_CTL_NINE 4
`define DSWSL_CTL_OE 5
`define DSWSL_CTL_DH 6
`define DSWSL_CTL_CR 7
`define DSWSL_CTL_FC 8

// Status register fields
`define DSWSL_ST_TXBUSY 0
`define DSWSL_ST_RXVALID 1
`define DSWSL_ST_FRAMERR 2
`define DSWSL_ST_COLL 3
`define DSWSL_ST_INIT 4
`define DSWSL_ST_OMIT 5
`define DSWSL_ST_BREAK 6

// Reset values and limits
`define DSWSL_RELOAD_RST 16'h0080
`define DSWSL_RELOAD_EN_MAX 16'h0FFF
`define DSWSL_BREAK_CLKS 13'h1000
`define DSWSL_ABD_CHAR_DFLT 8'h80
`define DSWSL_ABD_CHAR_CR 8'h0D
`define DSWSL_CMD_READ_REV 8'h00
`define DSWSL_ABD_CR_RISES 2'h3

`endif

// File: rtl/dswsl_sync.v
// Purpose: two-stage synchronizer for the debug pin input
// Assumes: single clock, synchronous active-high reset
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module dswsl_sync (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire pin_in,
  output wire pin_sync
);
  reg meta_q;
  reg sync_q;

  // Idle line is high, so reset to high to avoid a false edge
  always @(posedge core_clk) begin
    if (reset) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else if (clk_en) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;
endmodule

// File: rtl/dswsl_abd.v
// Purpose: auto-baud detector measuring eight bit times
// Assumes: line_q is the synchronized pin, edges derived from it
// Notes: count saturates so a stuck line cannot wrap the result
`timescale 1ns/1ps
module dswsl_abd (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire arm,
  input wire sel_cr,
  input wire fall,
  input wire rise,
  output reg done_q,
  output reg [15:0] count_q
);
  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_CNT = 2'd2;
  reg [1:0] state_q;
  reg [1:0] rises_q;

  // 80H: fall of start to rise of D7; 0DH: first rise to third rise
  always @(posedge core_clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      rises_q <= 2'h0;
      done_q <= 1'b0;
      count_q <= 16'h0000;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (count_q != 16'hFFFF)
        count_q <= count_q + 16'h0001;
      case (state_q)
        S_IDLE: begin
          if (arm && fall) begin
            count_q <= 16'h0001;
            state_q <= sel_cr ? S_WAIT : S_CNT;
          end
        end
        S_WAIT: begin
          if (!arm) begin
            state_q <= S_IDLE;
          end else if (rise) begin
            count_q <= 16'h0001;
            rises_q <= 2'h1;
            state_q <= S_CNT;
          end
        end
        S_CNT: begin
          if (!arm) begin
            state_q <= S_IDLE;
          end else if (rise) begin
            rises_q <= rises_q + 2'h1;
            if (!sel_cr || (rises_q + 2'h1) == `DSWSL_ABD_CR_RISES) begin
              done_q <= 1'b1;
              count_q <= count_q; // Hold the span, the reload takes it next cycle
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// File: dv/dswsl_top_properties.sv
// Purpose: port-level assertions for the debug serial link
// Assumes: one clock, synchronous active-high reset
// Notes: break length judged only on low drives longer than 2000 clocks
`timescale 1ns/1ps
module dswsl_chk (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire clock_changed,
  input wire debug_pin_out,
  input wire debug_pin_oe,
  input wire debug_pin_owned,
  input wire cmd_abort_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire drv_lo = debug_pin_oe & ~debug_pin_out;
  wire acc = psel & penable;
  wire ctl_wr = acc & pwrite & (paddr == 12'h000);
  reg [12:0] run_q;
  // Low drive length; frozen with the clock enable like the design
  always @(posedge core_clk) begin
    if (reset)
      run_q <= 13'h0000;
    else if (clk_en)
      run_q <= drv_lo ? run_q + 13'h0001 : 13'h0000;
  end
  sequence brk_s;
    drv_lo [*8];
  endsequence
  reset_state_a: assert property (
    $past(reset) |-> debug_pin_owned && !debug_pin_oe && !cmd_abort_q)
    else $error("state after reset wrong");
  owned_change_a: assert property (
    $changed(debug_pin_owned) |-> $past(ctl_wr) || $past(reset))
    else $error("pin ownership changed without control write");
  abort_break_a: assert property (
    cmd_abort_q |-> ##[0:2] brk_s)
    else $error("abort without break drive");
  break_len_a: assert property (
    $fell(drv_lo) && run_q > 13'h07D0 |-> run_q == 13'h1000)
    else $error("break length wrong");
  abort_pulse_a: assert property (
    cmd_abort_q && clk_en |=> !cmd_abort_q)
    else $error("abort longer than one cycle");
  clk_change_a: assert property (
    clock_changed && clk_en && debug_pin_owned |-> ##[1:4] cmd_abort_q)
    else $error("clock change did not break");
  slverr_phase_a: assert property (
    pslverr |-> acc)
    else $error("error outside access phase");
  unmapped_zero_a: assert property (
    acc && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  mapped_ok_a: assert property (
    acc && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped address refused");
  ready_high_a: assert property (
    pready)
    else $error("wait state inserted");
endmodule
bind dswsl_top dswsl_chk dswsl_chk_i (.core_clk, .reset, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pready, .prdata, .pslverr, .clock_changed, .debug_pin_out, .debug_pin_oe,
  .debug_pin_owned, .cmd_abort_q);

// File: dv/dswsl_host.sv
// Purpose: host serial port model on the far side of the debug pin
// Assumes: the line has a pull-up; the host only pulls low
// Notes: bit time and nine-bit mode are set by the bench
`timescale 1ns/1ps
module dswsl_host (
  input wire core_clk,
  input wire line,
  output logic pull_lo
);
  int bit_t = 12;
  bit nine = 1'b0;
  bit busy = 1'b0;
  logic [8:0] got_q;
  int got_n = 0;
  initial pull_lo = 1'b0;
  // One character; stop level selectable to provoke framing faults
  task automatic send(input logic [8:0] d, input logic stp);
    busy = 1'b1;
    @(posedge core_clk);
    pull_lo <= 1'b1;
    repeat (bit_t) @(posedge core_clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      pull_lo <= ~d[i];
      repeat (bit_t) @(posedge core_clk);
    end
    pull_lo <= ~stp;
    // One short, so a following start lands exactly one bit later
    repeat (bit_t - 1) @(posedge core_clk);
    pull_lo <= 1'b0;
    busy = 1'b0;
  endtask
  // Start pulse alone, the leading edge of an all-ones request
  task automatic req_start();
    @(posedge core_clk);
    pull_lo <= 1'b1;
    repeat (bit_t) @(posedge core_clk);
    pull_lo <= 1'b0;
  endtask
  // Too short to survive the mid-start sample
  task automatic glitch();
    busy = 1'b1;
    @(posedge core_clk);
    pull_lo <= 1'b1;
    repeat (3) @(posedge core_clk);
    pull_lo <= 1'b0;
    repeat (2 * bit_t) @(posedge core_clk);
    busy = 1'b0;
  endtask
  // Mid-bit sampling; never drives while listening
  always begin : rx_p
    @(negedge line);
    if (!busy) begin
      got_q = 9'h000;
      repeat (bit_t / 2) @(posedge core_clk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (bit_t) @(posedge core_clk);
        got_q[i] = line;
      end
      repeat (bit_t) @(posedge core_clk);
      got_n++;
      while (!line) @(posedge core_clk);
    end
  end
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench for the debug serial link
// Assumes: host model on the pin, 25 MHz core clock
// Notes: calibrated to 12 clocks per bit to keep the run short
`timescale 1ns/1ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module tb;
  typedef struct packed {logic [8:0] ctl; logic [8:0] dat; logic [8:0] exp;} dswsl_row_t;
  logic core_clk, reset, clk_en, psel, penable, pwrite, clock_changed, host_lo, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, pin_out, pin_oe, owned;
  wire pin = (pin_oe ? pin_out : 1'b1) & ~host_lo;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n, t;
  dswsl_row_t rows [7] = '{'{9'h001, 9'h1A5, 9'h0A5}, '{9'h021, 9'h05A, 9'h05A},
    '{9'h041, 9'h0F0, 9'h0F0}, '{9'h061, 9'h00F, 9'h00F}, '{9'h011, 9'h1C3, 9'h1C3},
    '{9'h031, 9'h03C, 9'h03C}, '{9'h101, 9'h0FF, 9'h0FF}};
  dswsl_top dswsl_top_i (.core_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .pin_share_option(1'b0), .clock_changed,
    .debug_pin_in(pin), .debug_pin_out(pin_out), .debug_pin_oe(pin_oe),
    .debug_pin_owned(owned), .cmd_abort_q());
  dswsl_host dswsl_host_i (.core_clk, .line(pin), .pull_lo(host_lo));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Wait for a host character, then for the stop bit to finish
  task automatic hwait(input int n0);
    t = 0;
    while (dswsl_host_i.got_n == n0 && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    if (t >= 3000) begin
      n_mismatch++;
      summarize();
    end
    repeat (dswsl_host_i.bit_t) @(posedge core_clk);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected 15k cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    {reset, clk_en} = 2'h3;
    {psel, penable, pwrite, clock_changed} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rchk(12'h000, 32'h9);
    rchk(12'h004, 32'h80);
    rchk(12'h020, 32'h0);
    `CHK(err, 1'b1)
    dswsl_host_i.send(9'h080, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h60)
    rchk(12'h000, 32'h1);
    // Transmit table: control, data, character seen by the host
    for (int i = 0; i < 7; i++) begin
      dswsl_host_i.nine = rows[i].ctl[4];
      apb(1'b1, 12'h000, {23'h0, rows[i].ctl});
      n = dswsl_host_i.got_n;
      apb(1'b1, 12'h008, {23'h0, rows[i].dat});
      if (rows[i].ctl[8])
        dswsl_host_i.req_start();
      hwait(n);
      `CHK(dswsl_host_i.got_q, rows[i].exp)
    end
    // Receive: discard before 00H, false start, back-to-back characters
    apb(1'b1, 12'h000, 32'h1);
    dswsl_host_i.nine = 1'b0;
    dswsl_host_i.send(9'h055, 1'b1);
    rchk(12'h00C, 32'h0);
    dswsl_host_i.glitch();
    dswsl_host_i.send(9'h000, 1'b1);
    rchk(12'h00C, 32'h32);
    rchk(12'h010, 32'h0);
    dswsl_host_i.send(9'h03C, 1'b1);
    fork
      dswsl_host_i.send(9'h0C3, 1'b1);
      rchk(12'h010, 32'h3C);
    join
    rchk(12'h010, 32'hC3);
    dswsl_host_i.send(9'h011, 1'b0);
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({rd[6], rd[2]}, 2'h3)
    repeat (4200) @(posedge core_clk);
    rchk(12'h000, 32'h9);
    dswsl_host_i.send(9'h080, 1'b1);
    apb(1'b1, 12'h000, 32'h81);
    rchk(12'h000, 32'h1);
    // Host holds the line low across the first data bit: collision
    apb(1'b1, 12'h008, 32'hFF);
    dswsl_host_i.req_start();
    dswsl_host_i.req_start();
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({rd[6], rd[3]}, 2'h3)
    apb(1'b1, 12'h00C, 32'h2C);
    rchk(12'h00C, 32'h51);
    repeat (4200) @(posedge core_clk);
    apb(1'b1, 12'h004, 32'hFFFF);
    rchk(12'h004, 32'hFFF);
    clock_changed <= 1'b1;
    @(posedge core_clk);
    clock_changed <= 1'b0;
    repeat (4200) @(posedge core_clk);
    rchk(12'h000, 32'h9);
    // Disabled: wide reload, carriage-return calibration, then lock
    apb(1'b1, 12'h000, 32'h0);
    `CHK(owned, 1'b0)
    apb(1'b1, 12'h004, 32'hFFFF);
    rchk(12'h004, 32'hFFFF);
    apb(1'b1, 12'h000, 32'h88);
    rchk(12'h000, 32'h88);
    dswsl_host_i.bit_t = 10;
    dswsl_host_i.send(9'h00D, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h50)
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h000, 32'h0);
    `CHK(owned, 1'b1)
    clk_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rchk(12'h000, 32'h9);
    summarize();
  end
endmodule
